// ### design/led_indicator_pkg.sv
// Shared constants and types for the controller status indicator block.
// Function
// - Health steady on when checks, init pass
// - Problem: health off, error code flash
// - Halt: health blinks, other status off
// - Boot: health, run, output blink together, other status off
// - Run indicator follows run mode
// - Output indicator follows output scan enable
// - Force indicator on while override active
// - Battery off, blink low, on failed
// - Low blink needs revision and smart battery
// - Fault indicator on after fatal fault
// - Serial activity indicators blink on traffic
// - Eight status plus two activity outputs
package led_indicator_pkg;

    localparam int unsigned CLK_HZ            = 250_000_000;
    localparam int unsigned BLINK_UNIT_US     = 1000;
    localparam int unsigned BLINK_UNIT_CYCLES = (CLK_HZ / 1_000_000) * BLINK_UNIT_US;

    localparam int          HALF_W_DEFAULT    = 8;
    localparam int          ERR_CODE_W        = 4;
    localparam int          ERR_STEP_W        = 6;
    localparam logic [5:0]  ERR_GAP_HALVES    = 6'h06;
    localparam int          SERIAL_PORTS      = 2;
    localparam int          STATUS_LEDS       = 8;

    typedef enum logic [3:0] {
        MODE_NORMAL  = 4'h1,
        MODE_PROBLEM = 4'h2,
        MODE_HALT    = 4'h4,
        MODE_BOOT    = 4'h8
    } mode_e;

    // Length of one error code frame in blink half periods.
    function automatic logic [ERR_STEP_W-1:0] err_frame_len(input logic [ERR_CODE_W-1:0] code);
        err_frame_len = {1'b0, code, 1'b0} + ERR_GAP_HALVES;
    endfunction : err_frame_len

endpackage : led_indicator_pkg

// ### design/blink_if.sv
// Carrier for the shared blink phase and its half period tick.
`timescale 1ns/1ns
`default_nettype none
interface blink_if;
    logic phase;
    logic half_tick;
    modport source (output phase, output half_tick);
    modport sink   (input phase, input half_tick);
endinterface : blink_if
`default_nettype wire

// ### design/blink_divider.sv
// Programmable blink divider shared by every blinking indicator.
`timescale 1ns/1ns
`default_nettype none
module blink_divider
    import led_indicator_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = BLINK_UNIT_CYCLES,
    parameter int          HALF_W      = HALF_W_DEFAULT
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [HALF_W-1:0] half_units,
    blink_if.source                blink
);

    localparam int PRE_W = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

    if (UNIT_CYCLES < 2 || HALF_W < 1)
    begin : g_bad_size
        $error("blink_divider: UNIT_CYCLES must be at least 2 and HALF_W at least 1");
    end

    logic [PRE_W-1:0]  pre_reg;
    logic [HALF_W-1:0] half_reg;
    logic              unit_tick;
    logic [HALF_W-1:0] half_last;

    assign unit_tick = (pre_reg == PRE_LAST);
    // A zero setting would stall the blink; it is served as one unit.
    assign half_last = (half_units == '0) ? '0 : half_units - HALF_W'(1);

    always_ff @(posedge clk)
    begin
        if (!rst_n || unit_tick)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + PRE_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            half_reg        <= '0;
            blink.phase     <= 1'b0;
            blink.half_tick <= 1'b0;
        end
        else
        begin
            blink.half_tick <= 1'b0;
            if (unit_tick)
            begin
                if (half_reg >= half_last)
                begin
                    half_reg        <= '0;
                    blink.phase     <= ~blink.phase;
                    blink.half_tick <= 1'b1;
                end
                else
                    half_reg <= half_reg + HALF_W'(1);
            end
        end
    end

endmodule : blink_divider
`default_nettype wire

// ### design/status_led_indicator.sv
// Front panel status and serial activity indicator driver.
`timescale 1ns/1ns
`default_nettype none
module status_led_indicator
    import led_indicator_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = BLINK_UNIT_CYCLES,
    parameter int          HALF_W      = HALF_W_DEFAULT
)(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Blink half period in units of the divider prescale.
    input  wire logic [HALF_W-1:0]     blink_half_units,
    // Controller state, all on this clock.
    input  wire logic                  diag_passed,
    input  wire logic                  init_done,
    input  wire logic                  cpu_problem,
    input  wire logic [ERR_CODE_W-1:0] error_code,
    input  wire logic                  halted,
    input  wire logic                  boot_mode,
    input  wire logic                  run_mode,
    input  wire logic                  output_scan_enabled,
    input  wire logic                  override_active,
    input  wire logic                  battery_low,
    input  wire logic                  battery_failed,
    input  wire logic                  smart_battery,
    input  wire logic                  hw_rev_low_detect,
    input  wire logic                  fatal_fault,
    input  wire logic                  serial_port_a_activity,
    input  wire logic                  serial_port_b_activity,
    // Status indicators, high lights the lamp.
    output logic                       led_health,
    output logic                       led_run,
    output logic                       led_output_scan_indicator,
    output logic                       led_force,
    output logic                       led_battery,
    output logic                       led_fatal_fault_label,
    output logic                       led_spare_a,
    output logic                       led_spare_b,
    // Serial activity indicators.
    output logic                       led_serial_port_a,
    output logic                       led_serial_port_b
);

    // Sizes that the blink and error code counters cannot serve are refused here.
    if (HALF_W < 1)
    begin : g_bad_half_width
        $error("status_led_indicator: HALF_W must be at least 1");
    end
    if (UNIT_CYCLES < 2)
    begin : g_bad_unit_cycles
        $error("status_led_indicator: UNIT_CYCLES must be at least 2");
    end
    if (ERR_STEP_W < ERR_CODE_W + 2)
    begin : g_bad_step_width
        $error("status_led_indicator: ERR_STEP_W cannot hold an error code frame");
    end

    blink_if blink ();

    blink_divider #(
        .UNIT_CYCLES (UNIT_CYCLES),
        .HALF_W      (HALF_W)
    ) u_blink_divider (
        .clk        (clk),
        .rst_n      (rst_n),
        .half_units (blink_half_units),
        .blink      (blink.source)
    );

    mode_e                 mode_reg;
    mode_e                 mode_next;
    logic [ERR_STEP_W-1:0] err_step_reg;
    logic                  err_lamp;
    logic                  health_ok;
    logic                  low_blink_allowed;
    logic [SERIAL_PORTS-1:0] act_pulse;
    logic [SERIAL_PORTS-1:0] act_hold_reg;
    logic [ERR_CODE_W-1:0]   err_code_reg;
    logic                    hold_clear;

    logic health_next;
    logic run_next;
    logic scan_next;
    logic force_next;
    logic battery_next;
    logic fault_next;

    assign act_pulse = {serial_port_b_activity, serial_port_a_activity};

    // An on half has just ended, so an idle port's hold may drop now.
    assign hold_clear = blink.half_tick && !blink.phase;

    // A blinking lamp is lit only in the on half of the shared phase.
    function automatic logic blink_lamp(input logic enable, input logic phase);
        blink_lamp = enable && phase;
    endfunction : blink_lamp

    assign health_ok = diag_passed && init_done && !cpu_problem;

    assign low_blink_allowed = hw_rev_low_detect && smart_battery;

    always_comb
    begin
        if (boot_mode)
            mode_next = MODE_BOOT;
        else if (halted)
            mode_next = MODE_HALT;
        else if (cpu_problem)
            mode_next = MODE_PROBLEM;
        else
            mode_next = MODE_NORMAL;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mode_reg <= MODE_NORMAL;
        else
            mode_reg <= mode_next;
    end

    // A new code restarts the frame, so no flash of the old code is miscounted.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            err_code_reg <= '0;
        else
            err_code_reg <= error_code;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || mode_reg != MODE_PROBLEM || error_code == '0 || error_code != err_code_reg)
            err_step_reg <= '0;
        else if (blink.half_tick)
        begin
            if (err_step_reg >= err_frame_len(error_code) - ERR_STEP_W'(1))
                err_step_reg <= '0;
            else
                err_step_reg <= err_step_reg + ERR_STEP_W'(1);
        end
    end

    // Odd steps are dark so each flash of the code stands apart.
    assign err_lamp = (err_step_reg < {1'b0, error_code, 1'b0}) && !err_step_reg[0];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            act_hold_reg <= '0;
        else
        begin
            for (int i = 0; i < SERIAL_PORTS; i++)
            begin
                // A pulse in the clearing cycle wins, so no traffic is missed.
                if (act_pulse[i])
                    act_hold_reg[i] <= 1'b1;
                else if (hold_clear)
                    act_hold_reg[i] <= 1'b0;
            end
        end
    end

    always_comb
    begin
        health_next  = 1'b0;
        run_next     = 1'b0;
        scan_next    = 1'b0;
        force_next   = 1'b0;
        battery_next = 1'b0;
        fault_next   = 1'b0;
        unique case (mode_reg)
            MODE_BOOT:
            begin
                health_next = blink.phase;
                run_next    = blink.phase;
                scan_next   = blink.phase;
            end
            MODE_HALT:
            begin
                health_next = blink.phase;
            end
            MODE_PROBLEM, MODE_NORMAL:
            begin
                health_next = (mode_reg == MODE_NORMAL) && health_ok;
                if (mode_reg == MODE_PROBLEM && error_code != '0)
                begin
                    run_next  = err_lamp;
                    scan_next = err_lamp;
                end
                else
                begin
                    run_next  = run_mode;
                    scan_next = output_scan_enabled;
                end
                force_next = override_active;
                if (battery_failed)
                    battery_next = 1'b1;
                else
                    battery_next = blink_lamp(battery_low && low_blink_allowed, blink.phase);
                fault_next = fatal_fault;
            end
        endcase
    end

    // Each lamp has its own register, so a change to one lamp's logic leaves the others alone.
    // health lamp register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_health <= 1'b0;
        else
            led_health <= health_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_run <= 1'b0;
        else
            led_run <= run_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_output_scan_indicator <= 1'b0;
        else
            led_output_scan_indicator <= scan_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_force <= 1'b0;
        else
            led_force <= force_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_battery <= 1'b0;
        else
            led_battery <= battery_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_fatal_fault_label <= 1'b0;
        else
            led_fatal_fault_label <= fault_next;
    end

    always_ff @(posedge clk)
    begin
        // The two remaining status lamps have no assigned meaning yet.
        led_spare_a <= 1'b0;
        led_spare_b <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_serial_port_a <= 1'b0;
        else
            led_serial_port_a <= blink_lamp(act_hold_reg[0], blink.phase);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            led_serial_port_b <= 1'b0;
        else
            led_serial_port_b <= blink_lamp(act_hold_reg[1], blink.phase);
    end

endmodule : status_led_indicator
`default_nettype wire

// ### bench/status_led_asserts.sv
// Concurrent checks on the status indicator block ports.
`timescale 1ns/1ns
`default_nettype none
module status_led_asserts
    import led_indicator_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = BLINK_UNIT_CYCLES,
    parameter int          HALF_W      = HALF_W_DEFAULT
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic diag_passed,
    input wire logic init_done,
    input wire logic cpu_problem,
    input wire logic halted,
    input wire logic boot_mode,
    input wire logic run_mode,
    input wire logic output_scan_enabled,
    input wire logic override_active,
    input wire logic battery_low,
    input wire logic battery_failed,
    input wire logic smart_battery,
    input wire logic hw_rev_low_detect,
    input wire logic fatal_fault,
    input wire logic led_health,
    input wire logic led_run,
    input wire logic led_output_scan_indicator,
    input wire logic led_force,
    input wire logic led_battery,
    input wire logic led_fatal_fault_label,
    input wire logic led_spare_a,
    input wire logic led_spare_b,
    input wire logic led_serial_port_a,
    input wire logic led_serial_port_b
);
    // A mode check waits three samples, since a mode passes two registers.
    logic [2:0] qh, ph, hh, bh;
    wire logic  hok = diag_passed && init_done && !fatal_fault;
    wire logic  bq  = !battery_failed && !(battery_low && smart_battery && hw_rev_low_detect);
    always_ff @(posedge clk)
    begin
        qh <= rst_n ? {qh[1:0], !boot_mode && !halted && !cpu_problem} : 3'h0;
        ph <= rst_n ? {ph[1:0], cpu_problem && !halted && !boot_mode} : 3'h0;
        hh <= rst_n ? {hh[1:0], halted && !boot_mode} : 3'h0;
        bh <= rst_n ? {bh[1:0], boot_mode} : 3'h0;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_spares_dark: assert property (!led_spare_a && !led_spare_b)
        else $error("spare lamp lit");
    chk_health_on: assert property (&qh && $past(hok) |-> led_health)
        else $error("health lamp dark");
    chk_problem_dark: assert property (&ph |-> !led_health)
        else $error("health lit on problem");
    chk_halt_blank: assert property (&hh |-> !(led_run || led_output_scan_indicator || led_force
        || led_battery || led_fatal_fault_label))
        else $error("status lamp lit in halt");
    chk_boot_unison: assert property (&bh |-> led_run == led_health && led_output_scan_indicator == led_health)
        else $error("boot lamps apart");
    chk_run_follows: assert property (&qh |-> led_run == $past(run_mode))
        else $error("run lamp wrong");
    chk_scan_follows: assert property (&qh |-> led_output_scan_indicator == $past(output_scan_enabled))
        else $error("scan lamp wrong");
    chk_force_follows: assert property (&qh |-> led_force == $past(override_active))
        else $error("force lamp wrong");
    chk_battery_failed: assert property (&qh && $past(battery_failed) |-> led_battery)
        else $error("battery lamp dark");
    chk_battery_quiet: assert property (&qh && $past(bq) |-> !led_battery)
        else $error("battery lamp lit");
    chk_fault_lamp: assert property (&qh |-> led_fatal_fault_label == $past(fatal_fault))
        else $error("fault lamp wrong");
    cover property (&bh && led_health);
    cover property (&hh && led_health);
    cover property (&ph && led_run);
    cover property ($rose(led_serial_port_a));
    cover property ($rose(led_serial_port_b));
endmodule : status_led_asserts
bind status_led_indicator status_led_asserts #(.UNIT_CYCLES(UNIT_CYCLES), .HALF_W(HALF_W)) chk_u (.*);
`default_nettype wire

// ### bench/led_panel_model.sv
// Operator view of the front panel: counts flashes of each lamp.
`timescale 1ns/1ns
`default_nettype none
module led_panel_model (
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic [9:0] lamp,
    output logic [7:0]      flashes [10]
);
    logic [9:0] prev_reg;
    always_ff @(posedge clk)
    begin
        prev_reg <= lamp;
        for (int i = 0; i < 10; i++)
            flashes[i] <= clr ? 8'h00 : flashes[i] + 8'(lamp[i] && !prev_reg[i]);
    end
endmodule : led_panel_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the status indicator block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clr = 1'b0;
    logic [14:0] ctl = 15'h0000;
    logic [3:0]  ec = 4'h0;
    logic [7:0]  hu = 8'h02;
    wire logic [9:0] lv;
    logic [7:0]  fl [10];
    logic [14:0] bv [6] = '{15'h0103, 15'h0503, 15'h0903, 15'h0f03, 15'h0203, 15'h0d03};
    logic [9:0]  bf [6] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h004};
    logic [9:0]  be [6] = '{10'h000, 10'h000, 10'h000, 10'h010, 10'h010, 10'h000};
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    always #2 clk = ~clk;
    status_led_indicator #(.UNIT_CYCLES(4)) dut_u (
        .clk(clk), .rst_n(rst_n), .blink_half_units(hu), .error_code(ec),
        .diag_passed(ctl[0]), .init_done(ctl[1]), .cpu_problem(ctl[2]), .halted(ctl[3]),
        .boot_mode(ctl[4]), .run_mode(ctl[5]), .output_scan_enabled(ctl[6]), .override_active(ctl[7]),
        .battery_low(ctl[8]), .battery_failed(ctl[9]), .smart_battery(ctl[10]),
        .hw_rev_low_detect(ctl[11]), .fatal_fault(ctl[12]),
        .serial_port_a_activity(ctl[13]), .serial_port_b_activity(ctl[14]),
        .led_health(lv[0]), .led_run(lv[1]), .led_output_scan_indicator(lv[2]), .led_force(lv[3]),
        .led_battery(lv[4]), .led_fatal_fault_label(lv[5]), .led_spare_a(lv[6]), .led_spare_b(lv[7]),
        .led_serial_port_a(lv[8]), .led_serial_port_b(lv[9])
    );
    led_panel_model panel_u (.clk(clk), .clr(clr), .lamp(lv), .flashes(fl));
    task automatic complete_run();
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic look(input string name, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : look
    // Four edges let a mode change pass both registers before sampling.
    task automatic put(input logic [14:0] v);
        @(posedge clk);
        #1 ctl = v;
        repeat (4) @(posedge clk);
        #1;
    endtask : put
    task automatic blinks(input int n, input logic [14:0] p);
        @(posedge clk);
        #1 clr = 1'b1;
        ctl = ctl ^ p;
        @(posedge clk);
        #1 clr = 1'b0;
        ctl = ctl ^ p;
        repeat (n) @(posedge clk);
        #1;
    endtask : blinks
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_total++;
            complete_run();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        #1 look("reset", lv, 10'h000);
        rst_n = 1'b1;
        put(15'h00e3);
        look("normal", lv, 10'h00f);
        put(15'h0003);
        look("idle", lv, 10'h001);
        put(15'h1003);
        look("fault", lv & 10'h03e, 10'h020);
        foreach (bv[i])
        begin
            put(bv[i]);
            blinks(64, 15'h0000);
            look("battery flashes", {2'h0, fl[4]}, bf[i]);
            if (bf[i] === 10'h000)
                look("battery", lv & 10'h010, be[i]);
        end
        put(15'h0067);
        look("problem", lv & 10'h007, 10'h006);
        for (int c = 1; c < 4; c++)
        begin
            ec = 4'(c);
            put(15'h0007);
            blinks(16 * (2 * c + 6), 15'h0000);
            look("code run", {2'h0, fl[1]}, 10'(2 * c));
            look("code scan", {2'h0, fl[2]}, 10'(2 * c));
            look("code health", {2'h0, fl[0]}, 10'h000);
        end
        ec = 4'h0;
        put(15'h10eb);
        blinks(64, 15'h0000);
        look("halt health", {2'h0, fl[0]}, 10'h004);
        look("halt others", lv & 10'h03e, 10'h000);
        hu = 8'h01;
        put(15'h10eb);
        blinks(64, 15'h0000);
        look("fast halt", {2'h0, fl[0]}, 10'h008);
        hu = 8'h00;
        put(15'h10eb);
        blinks(64, 15'h0000);
        look("zero half", {2'h0, fl[0]}, 10'h008);
        hu = 8'h02;
        put(15'h10fb);
        blinks(64, 15'h0000);
        look("boot health", {2'h0, fl[0]}, 10'h004);
        look("boot run", {2'h0, fl[1]}, 10'h004);
        look("boot scan", {2'h0, fl[2]}, 10'h004);
        look("boot others", lv & 10'h038, 10'h000);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 look("mid reset", lv, 10'h000);
        rst_n = 1'b1;
        put(15'h0003);
        blinks(64, 15'h2000);
        look("port a pulse", {2'h0, fl[8]}, 10'h001);
        look("port b idle", {2'h0, fl[9]}, 10'h000);
        put(15'h4003);
        blinks(64, 15'h0000);
        look("port b busy", {2'h0, fl[9]}, 10'h004);
        look("port a idle", {2'h0, fl[8]}, 10'h000);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
